// ---- src/rf_frontend_consts.svh ----
`ifndef RF_FRONTEND_CONSTS_SVH
`define RF_FRONTEND_CONSTS_SVH

// Register indexes as printed; byte address is four times the index.
`define RF_IDX_TX_CLOCK_CONTROL    8'h21
`define RF_IDX_RX_FRONTEND_CONTROL 8'h22
`define RF_IDX_FIELD_LEVEL_DET     8'h23
`define RF_IDX_CHIP_STATUS_FLAGS   8'h24
`define RF_IDX_TEMP_SENSOR_CONTROL 8'h25
`define RF_IDX_CARD_CHECK_RESULT   8'h26
`define RF_IDX_TX_POWER_CONFIG     8'h27

// Writable bit masks per register.
`define RF_MASK_TX_CLOCK   32'h0000_00FF
`define RF_MASK_RX_FRONT   32'h0000_00FF
`define RF_MASK_FIELD_DET  32'h0000_7FFF
`define RF_MASK_TEMP       32'h0000_000F
`define RF_MASK_CARD_CHECK 32'h0000_3FFF
`define RF_MASK_TX_POWER   32'h000F_FFFF

// Reset values.
`define RF_RST_ZERO 32'h0000_0000

// Field positions.
`define RF_POS_DRV2_INV_READER 7
`define RF_POS_DRV2_INV_CARD   6
`define RF_POS_DRV1_INV_READER 5
`define RF_POS_DRV1_INV_CARD   4
`define RF_POS_PHASE_LOOP_ON   0
`define RF_POS_NFD_POWERDOWN   14
`define RF_POS_TEMP_HYST       3
`define RF_POS_TEMP_ENABLE     2
`define RF_POS_FORCE_MAX       3
`define RF_POS_REF_TO_SUPPLY   0

`endif

// ---- src/rf_frontend_pkg.sv ----
package rf_frontend_pkg;

  typedef enum logic [1:0] {
    MIX_OFF_A,
    MIX_READER,
    MIX_CARD,
    MIX_OFF_B
  } mixer_sel_e;

  typedef enum logic [1:0] {
    FDET_NEAR_FIELD,
    FDET_LEVEL_DET,
    FDET_BOTH,
    FDET_FORCED
  } field_source_e;

  typedef enum logic [1:0] {
    CHK_IDLE,
    CHK_MEASURE,
    CHK_DONE
  } check_state_e;

endpackage : rf_frontend_pkg

// ---- src/rf_frontend_control_regs.sv ----
`timescale 1ns/100ps
`include "rf_frontend_consts.svh"

module rf_frontend_control_regs #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic      [31:0]       reg_rdata_o,
  // Carrier clocks and driver outputs
  input  wire logic              carrier_clock_i,
  output logic                   drv1_tx_clk_o,
  output logic                   drv2_tx_clk_o,
  input  wire logic              reader_mode_i,
  output logic      [2:0]        reader_tx_clocking_sel_o,
  output logic                   phase_loop_on_o,
  // Receiver settings
  output logic                   reader_mixer_en_o,
  output logic                   card_mixer_en_o,
  output logic      [1:0]        highpass_corner_sel_o,
  output logic      [1:0]        baseband_gain_sel_o,
  output logic      [1:0]        miller_demod_ref_level_o,
  // Field detection
  input  wire logic              near_field_detected_i,
  input  wire logic              level_detected_i,
  output logic                   field_present_o,
  output logic                   near_field_detector_powerdown_o,
  output logic      [3:0]        near_field_detect_level_o,
  output logic      [3:0]        level_detector_ref_a_o,
  output logic      [3:0]        level_detector_ref_b_o,
  // Status sources from the system
  input  wire logic [2:0]        host_error_flags_i,
  input  wire logic              standby_blocked_by_field_i,
  input  wire logic [4:0]        boot_cause_i,
  // Temperature sensor
  output logic                   temp_sensor_on_o,
  output logic                   thermal_hysteresis_on_o,
  output logic      [1:0]        temp_threshold_sel_o,
  // Card check measurement
  output logic                   card_check_start_o,
  output logic                   card_check_busy_o,
  input  wire logic              card_check_done_i,
  input  wire logic [3:0]        power_gear_reading_i,
  input  wire logic [9:0]        gain_control_reading_i,
  output logic      [13:0]       card_detect_reference_o,
  // Transmitter power control
  output logic      [3:0]        card_carrier_conductance_o,
  output logic      [3:0]        card_modulation_conductance_o,
  output logic      [3:0]        reader_modulation_conductance_o,
  output logic      [3:0]        reader_carrier_conductance_o,
  output logic                   reader_carrier_force_max_o,
  output logic      [1:0]        reader_carrier_amplitude_o,
  output logic                   carrier_ref_to_tx_supply_o
);

  logic [31:0] tx_clock_q;
  logic [31:0] rx_front_q;
  logic [31:0] field_det_q;
  logic [31:0] temp_q;
  logic [31:0] card_ref_q;
  logic [31:0] card_result_q;
  logic [31:0] tx_power_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [8:0]  status_seen;
  localparam int PIN_SYNC_W = 11;
  logic [PIN_SYNC_W-1:0] async_in;
  logic [PIN_SYNC_W-1:0] async_seen;
  logic        field_present_q;
  logic        reader_mixer_q;
  logic        card_mixer_q;
  logic        check_launch;
  logic [1:0]  inv_reader;
  logic [1:0]  inv_card;
  logic [1:0]  drv_clk;
  rf_frontend_pkg::mixer_sel_e    mixer_sel;
  rf_frontend_pkg::field_source_e fsrc;
  rf_frontend_pkg::check_state_e  chk_q;

  // Register index: byte address divided by four.
  function automatic logic [ADDR_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr >> 2;
  endfunction : reg_index

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    hit = (reg_index(addr) == ADDR_W'(idx));
  endfunction : hit

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_clock_q <= `RF_RST_ZERO;
    end else if (reg_write_i && hit(reg_addr_i, `RF_IDX_TX_CLOCK_CONTROL)) begin
      tx_clock_q <= reg_wdata_i & `RF_MASK_TX_CLOCK;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_front_q <= `RF_RST_ZERO;
    end else if (reg_write_i && hit(reg_addr_i, `RF_IDX_RX_FRONTEND_CONTROL)) begin
      rx_front_q <= reg_wdata_i & `RF_MASK_RX_FRONT;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      field_det_q <= `RF_RST_ZERO;
    end else if (reg_write_i && hit(reg_addr_i, `RF_IDX_FIELD_LEVEL_DET)) begin
      field_det_q <= reg_wdata_i & `RF_MASK_FIELD_DET;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      temp_q <= `RF_RST_ZERO;
    end else if (reg_write_i && hit(reg_addr_i, `RF_IDX_TEMP_SENSOR_CONTROL)) begin
      temp_q <= reg_wdata_i & `RF_MASK_TEMP;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_power_q <= `RF_RST_ZERO;
    end else if (reg_write_i && hit(reg_addr_i, `RF_IDX_TX_POWER_CONFIG)) begin
      tx_power_q <= reg_wdata_i & `RF_MASK_TX_POWER;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      card_ref_q <= `RF_RST_ZERO;
    end else if (reg_write_i && hit(reg_addr_i, `RF_IDX_CARD_CHECK_RESULT)) begin
      card_ref_q <= reg_wdata_i & `RF_MASK_CARD_CHECK;
    end
  end

  // Check sequence: a read launches one measurement; reads during it do not restart it.
  // read launches check
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      chk_q <= rf_frontend_pkg::CHK_IDLE;
    end else begin
      unique case (chk_q)
        rf_frontend_pkg::CHK_IDLE: begin
          if (check_launch) begin
            chk_q <= rf_frontend_pkg::CHK_MEASURE;
          end
        end
        rf_frontend_pkg::CHK_MEASURE: begin
          if (card_check_done_i) begin
            chk_q <= rf_frontend_pkg::CHK_DONE;
          end
        end
        rf_frontend_pkg::CHK_DONE: begin
          chk_q <= rf_frontend_pkg::CHK_IDLE;
        end
        default: begin
          chk_q <= rf_frontend_pkg::CHK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      card_result_q <= `RF_RST_ZERO;
    end else if (chk_q == rf_frontend_pkg::CHK_MEASURE && card_check_done_i) begin
      card_result_q <= {18'h0_0000, power_gear_reading_i, gain_control_reading_i};
    end
  end

  // Detector and status pins arrive from other clock domains. Each bit passes three stages, and a
  // change is taken only once stages two and three agree, so a one-cycle glitch never gets through.
  assign async_in = {host_error_flags_i, standby_blocked_by_field_i, boot_cause_i,
                     near_field_detected_i, level_detected_i};

  for (genvar g = 0; g < PIN_SYNC_W; g++) begin : g_pin_sync
    logic [2:0] stage_q;
    logic       agreed_q;
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        stage_q <= 3'h0;
      end else begin
        stage_q <= {stage_q[1:0], async_in[g]};
      end
    end
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        agreed_q <= 1'h0;
      end else if (stage_q[1] == stage_q[2]) begin
        agreed_q <= stage_q[2];
      end
    end
    assign async_seen[g] = agreed_q;
  end : g_pin_sync

  assign status_seen = async_seen[10:2];

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_read_i) begin
      unique case (reg_index(reg_addr_i))
        ADDR_W'(`RF_IDX_TX_CLOCK_CONTROL):    rdata_d = tx_clock_q;
        ADDR_W'(`RF_IDX_RX_FRONTEND_CONTROL): rdata_d = rx_front_q;
        ADDR_W'(`RF_IDX_FIELD_LEVEL_DET):     rdata_d = field_det_q;
        ADDR_W'(`RF_IDX_CHIP_STATUS_FLAGS):   rdata_d = {23'h00_0000, status_seen};
        ADDR_W'(`RF_IDX_TEMP_SENSOR_CONTROL): rdata_d = temp_q;
        ADDR_W'(`RF_IDX_CARD_CHECK_RESULT):   rdata_d = card_result_q;
        ADDR_W'(`RF_IDX_TX_POWER_CONFIG):     rdata_d = tx_power_q;
        default:                              rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  assign inv_reader = {tx_clock_q[`RF_POS_DRV2_INV_READER], tx_clock_q[`RF_POS_DRV1_INV_READER]};
  assign inv_card   = {tx_clock_q[`RF_POS_DRV2_INV_CARD], tx_clock_q[`RF_POS_DRV1_INV_CARD]};
  // The carrier is a separate analog-rate clock; this XOR is the only logic it sees.
  // Index 0 is driver one and index 1 driver two.
  for (genvar d = 0; d < 2; d++) begin : g_driver
    assign drv_clk[d] = carrier_clock_i ^ (reader_mode_i ? inv_reader[d] : inv_card[d]);
  end : g_driver
  assign drv1_tx_clk_o = drv_clk[0];
  assign drv2_tx_clk_o = drv_clk[1];

  assign reader_tx_clocking_sel_o = tx_clock_q[3:1];
  assign phase_loop_on_o          = tx_clock_q[`RF_POS_PHASE_LOOP_ON];

  // mixer decode
  // Decoding as the field is written keeps both enables on flip-flops, free of decode glitches.
  assign mixer_sel = rf_frontend_pkg::mixer_sel_e'(reg_wdata_i[5:4]);
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reader_mixer_q <= 1'h0;
      card_mixer_q   <= 1'h0;
    end else if (reg_write_i && hit(reg_addr_i, `RF_IDX_RX_FRONTEND_CONTROL)) begin
      reader_mixer_q <= (mixer_sel == rf_frontend_pkg::MIX_READER);
      card_mixer_q   <= (mixer_sel == rf_frontend_pkg::MIX_CARD);
    end
  end
  assign reader_mixer_en_o = reader_mixer_q;
  assign card_mixer_en_o   = card_mixer_q;
  assign highpass_corner_sel_o    = rx_front_q[3:2];
  assign baseband_gain_sel_o      = rx_front_q[1:0];
  assign miller_demod_ref_level_o = rx_front_q[7:6];

  assign fsrc = rf_frontend_pkg::field_source_e'(field_det_q[13:12]);
  // Registered so the indication moves once per clock, one cycle after the pin filter.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      field_present_q <= 1'h0;
    end else begin
      unique case (fsrc)
        rf_frontend_pkg::FDET_NEAR_FIELD: field_present_q <= async_seen[1];
        rf_frontend_pkg::FDET_LEVEL_DET:  field_present_q <= async_seen[0];
        rf_frontend_pkg::FDET_BOTH:       field_present_q <= async_seen[1] | async_seen[0];
        rf_frontend_pkg::FDET_FORCED:     field_present_q <= 1'h1;
      endcase
    end
  end
  assign field_present_o = field_present_q;
  assign near_field_detector_powerdown_o = field_det_q[`RF_POS_NFD_POWERDOWN];
  assign near_field_detect_level_o       = field_det_q[11:8];
  assign level_detector_ref_a_o          = field_det_q[7:4];
  assign level_detector_ref_b_o          = field_det_q[3:0];

  assign temp_threshold_sel_o    = temp_q[1:0];
  assign temp_sensor_on_o        = temp_q[`RF_POS_TEMP_ENABLE];
  assign thermal_hysteresis_on_o = temp_q[`RF_POS_TEMP_HYST];

  // A read of the result register launches a check only from idle; a read while busy just returns data.
  assign check_launch            = (chk_q == rf_frontend_pkg::CHK_IDLE) && reg_read_i
                                   && hit(reg_addr_i, `RF_IDX_CARD_CHECK_RESULT);
  assign card_check_start_o      = check_launch;
  assign card_check_busy_o       = (chk_q == rf_frontend_pkg::CHK_MEASURE);
  assign card_detect_reference_o = card_ref_q[13:0];

  assign card_carrier_conductance_o      = tx_power_q[19:16];
  assign card_modulation_conductance_o   = tx_power_q[15:12];
  assign reader_modulation_conductance_o = tx_power_q[11:8];
  assign reader_carrier_conductance_o    = tx_power_q[7:4];
  assign reader_carrier_force_max_o = tx_power_q[`RF_POS_FORCE_MAX];
  assign reader_carrier_amplitude_o = tx_power_q[2:1];
  assign carrier_ref_to_tx_supply_o = tx_power_q[`RF_POS_REF_TO_SUPPLY];

endmodule : rf_frontend_control_regs

// ---- test/rf_frontend_control_regs_properties.sv ----
`timescale 1ns/100ps

module rf_frontend_control_regs_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              core_clk_i,
  input wire logic              srst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic              reg_write_i,
  input wire logic              reg_read_i,
  input wire logic [31:0]       reg_rdata_o,
  input wire logic              carrier_clock_i,
  input wire logic              reader_mode_i,
  input wire logic              drv1_tx_clk_o,
  input wire logic              reader_mixer_en_o,
  input wire logic              card_mixer_en_o,
  input wire logic [1:0]        baseband_gain_sel_o,
  input wire logic              near_field_detected_i,
  input wire logic              level_detected_i,
  input wire logic              field_present_o,
  input wire logic              card_check_start_o,
  input wire logic              card_check_busy_o,
  input wire logic [13:0]       card_detect_reference_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_rd_idle; !reg_read_i |=> reg_rdata_o == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
  property p_rd_reserved; reg_read_i |=> reg_rdata_o[31:20] == 12'h000; endproperty
  a_rd_reserved: assert property (p_rd_reserved) else $error("reserved read bits not zero");
  // The carrier relation may only change when a write has landed or reader_mode_i has moved.
  property p_drv1_hold;
    $stable(reader_mode_i) && !$past(reg_write_i) |->
      (drv1_tx_clk_o ^ carrier_clock_i) == $past(drv1_tx_clk_o ^ carrier_clock_i);
  endproperty
  a_drv1_hold: assert property (p_drv1_hold) else $error("driver one clock polarity moved");
  property p_mixer_excl; !(reader_mixer_en_o && card_mixer_en_o); endproperty
  a_mixer_excl: assert property (p_mixer_excl) else $error("both mixers enabled");
  property p_gain_store; reg_write_i && reg_addr_i[7:2] == 6'h22 |=> baseband_gain_sel_o == $past(reg_wdata_i[1:0]);
  endproperty
  a_gain_store: assert property (p_gain_store) else $error("gain select not stored");
  // The pins pass three filter stages, an agreement register and an output register, so the indication lags by five clocks.
  property p_field_both; (near_field_detected_i && level_detected_i) [*6] |-> field_present_o; endproperty
  a_field_both: assert property (p_field_both) else $error("field not present with both detectors");
  property p_start_cause; card_check_start_o |-> reg_read_i && reg_addr_i[7:2] == 6'h26; endproperty
  a_start_cause: assert property (p_start_cause) else $error("check started without a read");
  property p_start_busy; card_check_start_o |=> card_check_busy_o; endproperty
  a_start_busy: assert property (p_start_busy) else $error("check not busy after start");
  property p_no_relaunch; card_check_busy_o |-> !card_check_start_o; endproperty
  a_no_relaunch: assert property (p_no_relaunch) else $error("check relaunched while busy");
  property p_ref_store;
    reg_write_i && reg_addr_i[7:2] == 6'h26 |=> card_detect_reference_o == $past(reg_wdata_i[13:0]);
  endproperty
  a_ref_store: assert property (p_ref_store) else $error("detection reference not stored");
endmodule : rf_frontend_control_regs_checker

bind rf_frontend_control_regs rf_frontend_control_regs_checker #(.ADDR_W(ADDR_W)) checker_i (
  .core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
  .carrier_clock_i, .reader_mode_i, .drv1_tx_clk_o, .reader_mixer_en_o, .card_mixer_en_o,
  .baseband_gain_sel_o, .near_field_detected_i, .level_detected_i, .field_present_o,
  .card_check_start_o, .card_check_busy_o, .card_detect_reference_o);

// ---- test/tb_rf_frontend_control_regs.sv ----
`timescale 1ns/100ps
`include "rf_frontend_consts.svh"

module tb_rf_frontend_control_regs;
  logic        core_clk_i, srst_i, reg_write_i, reg_read_i, carrier_clock_i, reader_mode_i;
  logic        near_field_detected_i, level_detected_i, standby_blocked_by_field_i, card_check_done_i;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [2:0]  host_error_flags_i, reader_tx_clocking_sel_o;
  logic [4:0]  boot_cause_i;
  logic [3:0]  power_gear_reading_i, near_field_detect_level_o, level_detector_ref_a_o, level_detector_ref_b_o;
  logic [9:0]  gain_control_reading_i;
  logic [13:0] card_detect_reference_o;
  logic        drv1_tx_clk_o, drv2_tx_clk_o, phase_loop_on_o, reader_mixer_en_o, card_mixer_en_o;
  logic [1:0]  highpass_corner_sel_o, baseband_gain_sel_o, miller_demod_ref_level_o, temp_threshold_sel_o;
  logic        field_present_o, near_field_detector_powerdown_o, temp_sensor_on_o, thermal_hysteresis_on_o;
  logic        card_check_start_o, card_check_busy_o, reader_carrier_force_max_o, carrier_ref_to_tx_supply_o;
  logic [3:0]  card_carrier_conductance_o, card_modulation_conductance_o;
  logic [3:0]  reader_modulation_conductance_o, reader_carrier_conductance_o;
  logic [1:0]  reader_carrier_amplitude_o;
  int          miscompares = 0;
  int          comparisons = 0;

  rf_frontend_control_regs rf_frontend_control_regs_i (
    .core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
    .carrier_clock_i, .drv1_tx_clk_o, .drv2_tx_clk_o, .reader_mode_i, .reader_tx_clocking_sel_o,
    .phase_loop_on_o, .reader_mixer_en_o, .card_mixer_en_o, .highpass_corner_sel_o, .baseband_gain_sel_o,
    .miller_demod_ref_level_o, .near_field_detected_i, .level_detected_i, .field_present_o,
    .near_field_detector_powerdown_o, .near_field_detect_level_o, .level_detector_ref_a_o,
    .level_detector_ref_b_o, .host_error_flags_i, .standby_blocked_by_field_i, .boot_cause_i,
    .temp_sensor_on_o, .thermal_hysteresis_on_o, .temp_threshold_sel_o, .card_check_start_o,
    .card_check_busy_o, .card_check_done_i, .power_gear_reading_i, .gain_control_reading_i,
    .card_detect_reference_o, .card_carrier_conductance_o, .card_modulation_conductance_o,
    .reader_modulation_conductance_o, .reader_carrier_conductance_o, .reader_carrier_force_max_o,
    .reader_carrier_amplitude_o, .carrier_ref_to_tx_supply_o);

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= {idx[5:0], 2'b00};
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
    #1;
  endtask : wr

  // Every read also checks whether it launched a card check.
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic st);
    @(posedge core_clk_i);
    reg_addr_i <= {idx[5:0], 2'b00};
    reg_read_i <= 1'b1;
    #1 chk(card_check_start_o, st);
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask : rd

  task automatic settle();
    @(posedge core_clk_i);
    #1;
  endtask : settle

  task automatic t_reset_and_masks();
    logic [31:0] m[7];
    m = '{`RF_MASK_TX_CLOCK, `RF_MASK_RX_FRONT, `RF_MASK_FIELD_DET, 32'h0, `RF_MASK_TEMP, 32'h0, `RF_MASK_TX_POWER};
    for (int i = 0; i < 7; i++) rd(8'h21 + 8'(i), `RF_RST_ZERO, i == 5);
    for (int i = 0; i < 7; i++) begin
      wr(8'h21 + 8'(i), 32'hFFFF_FFFF);
      rd(8'h21 + 8'(i), m[i], 1'b0);
    end
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, 1'b0);
  endtask : t_reset_and_masks

  task automatic t_tx_clock();
    for (int j = 0; j < 2; j++) begin
      wr(8'h21, j ? 32'h0000_006B : 32'h0000_009B);
      chk({reader_tx_clocking_sel_o, phase_loop_on_o}, 4'hB);
      for (int k = 0; k < 4; k++) begin
        carrier_clock_i <= k[0];
        reader_mode_i   <= k[1];
        settle();
        chk({drv2_tx_clk_o, drv1_tx_clk_o}, {k[0] ^ k[1] ^ j[0], k[0] ^ !k[1] ^ j[0]});
      end
    end
  endtask : t_tx_clock

  task automatic t_rx();
    for (int c = 0; c < 4; c++) begin
      wr(8'h22, {24'h0, 2'(c), 2'(c), 2'(c), 2'(3 - c)});
      chk({miller_demod_ref_level_o, reader_mixer_en_o, card_mixer_en_o, highpass_corner_sel_o,
           baseband_gain_sel_o}, {2'(c), c == 1, c == 2, 2'(c), 2'(3 - c)});
    end
  endtask : t_rx

  task automatic t_field();
    for (int s = 0; s < 4; s++) begin
      wr(8'h23, 32'h0000_495C | (s << 12));
      chk({near_field_detector_powerdown_o, near_field_detect_level_o, level_detector_ref_a_o,
           level_detector_ref_b_o}, 13'h195C);
      for (int k = 0; k < 4; k++) begin
        near_field_detected_i <= k[0];
        level_detected_i      <= k[1];
        repeat (5) settle();
        chk(field_present_o, s == 0 ? k[0] : s == 1 ? k[1] : s == 2 ? k[0] | k[1] : 1'b1);
      end
    end
  endtask : t_field

  task automatic t_status_temp();
    host_error_flags_i         <= 3'b101;
    standby_blocked_by_field_i <= 1'b1;
    boot_cause_i               <= 5'b10011;
    wr(8'h24, 32'hFFFF_FFFF);
    repeat (4) settle();
    rd(8'h24, 32'h0000_0173, 1'b0);
    host_error_flags_i         <= 3'b010;
    standby_blocked_by_field_i <= 1'b0;
    boot_cause_i               <= 5'b01100;
    repeat (4) settle();
    rd(8'h24, 32'h0000_008C, 1'b0);
    wr(8'h25, 32'hFFFF_FFF6);
    chk({thermal_hysteresis_on_o, temp_sensor_on_o, temp_threshold_sel_o}, 4'h6);
    wr(8'h25, 32'h0000_0009);
    chk({thermal_hysteresis_on_o, temp_sensor_on_o, temp_threshold_sel_o}, 4'h9);
  endtask : t_status_temp

  task automatic finish_measure();
    @(posedge core_clk_i);
    card_check_done_i <= 1'b1;
    @(posedge core_clk_i);
    card_check_done_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask : finish_measure

  // The check launched by the reset read is still pending here.
  task automatic t_card_check();
    finish_measure();
    power_gear_reading_i   <= 4'hA;
    gain_control_reading_i <= 10'h155;
    wr(8'h26, 32'hFFFF_EABC);
    chk(card_detect_reference_o, 14'h2ABC);
    rd(8'h26, 32'h0, 1'b1);
    chk(card_check_busy_o, 1'b1);
    rd(8'h26, 32'h0, 1'b0);
    finish_measure();
    rd(8'h26, 32'h0000_2955, 1'b1);
  endtask : t_card_check

  task automatic t_tx_power();
    wr(8'h27, 32'hFFFA_5C3B);
    chk({card_carrier_conductance_o, card_modulation_conductance_o, reader_modulation_conductance_o,
         reader_carrier_conductance_o, reader_carrier_force_max_o, reader_carrier_amplitude_o,
         carrier_ref_to_tx_supply_o}, 20'hA5C3B);
    rd(8'h27, 32'h000A_5C3B, 1'b0);
  endtask : t_tx_power

  task automatic finish_test();
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial begin
    {srst_i, reg_write_i, reg_read_i, carrier_clock_i, reader_mode_i} = 5'b10000;
    {near_field_detected_i, level_detected_i, standby_blocked_by_field_i, card_check_done_i} = 4'h0;
    {reg_addr_i, reg_wdata_i, host_error_flags_i, boot_cause_i} = '0;
    {power_gear_reading_i, gain_control_reading_i} = '0;
    repeat (5) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_reset_and_masks();
    t_tx_clock();
    t_rx();
    t_field();
    t_status_temp();
    t_card_check();
    t_tx_power();
    finish_test();
  end

  // A run this short needs well under a thousand cycles.
  initial begin
    #200us;
    miscompares++;
    finish_test();
  end
endmodule : tb_rf_frontend_control_regs
